// File: logic/bms_pkg.sv
// Package: constants and types for the block-move sequencer.
// Assumes a single-clock CPU core at 40 MHz with a simple memory bus.
package bms_pkg;

  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // ------------------------------------------------------------
  // Timing counts (states per instruction)
  // ------------------------------------------------------------
  localparam logic [3:0] BMS_SETUP_STATES = 4'h8;
  localparam logic [2:0] BMS_BYTE_STATES  = 3'h4;
  localparam logic [3:0] BMS_SETUP_LAST   = 4'h7;
  localparam logic [2:0] BMS_READ_STATE   = 3'h0;
  localparam logic [2:0] BMS_WRITE_STATE  = 3'h2;
  localparam logic [2:0] BMS_BYTE_LAST    = 3'h3;
  localparam logic [2:0] BMS_INSTR_BYTES  = 3'h4;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [15:0] BMS_CNT_RST = 16'h0000;
  localparam logic [15:0] BMS_PTR_RST = 16'h0000;

  typedef enum logic [1:0] {
    BMS_IDLE  = 2'b00,
    BMS_SETUP = 2'b01,
    BMS_MOVE  = 2'b10,
    BMS_DONE  = 2'b11
  } bms_state_t;

endpackage

// File: logic/bms_phase_cnt.sv
// Phase counter: counts states inside setup and per-byte phases.
// Assumes the same clock and clock enable as the sequencer.
`timescale 1ns/10ps
module bms_phase_cnt
  import bms_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       ce,
  input  wire logic       clr,
  input  wire logic       adv,
  output logic      [3:0] cnt
);
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 4'h0;
    end else if (ce) begin
      if (clr) begin
        cnt <= 4'h0;
      end else if (adv) begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule

// File: logic/bms_seq.sv
// Block-move sequencer: copies bytes source to destination.
// Assumes a memory bus that completes in one state unless mem_wait.
//
// Operation
// (R1) Byte form decrements 8-bit count until zero
// (R2) Word form uses 16-bit count until zero
// (R3) Read source, write destination, bump both pointers
// (R4) Zero count at start skips all transfers
// (R5) On-chip timing is 8 plus 4n states
// (R6) Slow-clock synchronised transfers stretch execution time
// (R7) Four-byte instruction; registers keep final values
`timescale 1ns/10ps
module bms_seq
  import bms_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              resetn,
  input  wire logic              ce,
  input  wire logic              start,
  input  wire logic              word_form,
  input  wire logic [15:0]       word_count_register_in,
  input  wire logic [15:0]       source_pointer_in,
  input  wire logic [15:0]       destination_pointer_in,
  input  wire logic              mem_wait,
  input  wire logic [7:0]        mem_rdata,
  output logic                   mem_rd,
  output logic                   mem_wr,
  output logic      [15:0]       mem_addr,
  output logic      [7:0]        mem_wdata,
  output logic      [15:0]       word_count_register,
  output logic      [15:0]       source_pointer,
  output logic      [15:0]       destination_pointer,
  output logic                   busy,
  output logic                   done,
  output logic      [2:0]        pc_advance
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  bms_state_t state_r;
  bms_state_t state_nxt;
  logic       word_r;
  logic [7:0] data_r;
  logic [3:0] phase;
  logic       ph_clr;
  logic       ph_adv;
  logic       cnt_zero;
  logic       last_byte;

  function automatic logic count_is_zero(input logic w,
                                         input logic [15:0] c);
    count_is_zero = w ? (c == 16'h0000) : (c[7:0] == 8'h00);
  endfunction

  assign cnt_zero  = count_is_zero(word_r, word_count_register);
  // Count already dropped at the write state, so zero means last
  assign last_byte = count_is_zero(word_r, word_count_register);

  bms_phase_cnt u_phase (
    .mclk   (mclk),
    .resetn (resetn),
    .ce     (ce),
    .clr    (ph_clr),
    .adv    (ph_adv),
    .cnt    (phase)
  );

  // ------------------------------------------------------------
  // Sequencing
  // ------------------------------------------------------------
  // Waits hold the phase still; that is what stretches timing
  assign ph_adv = (state_r == BMS_SETUP || state_r == BMS_MOVE)
                  && !mem_wait; // R6

  always_comb begin
    state_nxt = state_r;
    ph_clr    = 1'b0;
    case (state_r)
      BMS_IDLE: begin
        if (start) begin
          state_nxt = BMS_SETUP;
          ph_clr    = 1'b1;
        end
      end
      BMS_SETUP: begin
        if (phase == BMS_SETUP_LAST && !mem_wait) begin // R5
          ph_clr    = 1'b1;
          state_nxt = cnt_zero ? BMS_DONE : BMS_MOVE; // R4
        end
      end
      BMS_MOVE: begin
        if (phase[2:0] == BMS_BYTE_LAST && !mem_wait) begin
          ph_clr = 1'b1;
          if (last_byte) begin // R1 R2
            state_nxt = BMS_DONE;
          end
        end
      end
      BMS_DONE: state_nxt = BMS_IDLE;
      default:  state_nxt = BMS_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_r <= BMS_IDLE;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // ------------------------------------------------------------
  // Registers: pointers and count
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      word_r              <= 1'b0;
      word_count_register <= BMS_CNT_RST;
      source_pointer      <= BMS_PTR_RST;
      destination_pointer <= BMS_PTR_RST;
    end else if (ce) begin
      if (state_r == BMS_IDLE && start) begin
        word_r              <= word_form;
        word_count_register <= word_count_register_in;
        source_pointer      <= source_pointer_in;
        destination_pointer <= destination_pointer_in;
      end else if (state_r == BMS_MOVE && !mem_wait
                   && phase[2:0] == BMS_WRITE_STATE) begin
        source_pointer      <= source_pointer + 16'h0001; // R3
        destination_pointer <= destination_pointer + 16'h0001; // R3
        if (word_r) begin
          word_count_register <= word_count_register - 16'h0001; // R2
        end else begin
          // Upper byte of the word untouched in byte form
          word_count_register[7:0] <= word_count_register[7:0]
                                      - 8'h01; // R1
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Memory bus
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      data_r <= 8'h00;
    end else if (ce && state_r == BMS_MOVE && !mem_wait
                 && phase[2:0] == BMS_READ_STATE) begin
      data_r <= mem_rdata; // R3
    end
  end

  assign mem_rd    = state_r == BMS_MOVE
                     && phase[2:0] == BMS_READ_STATE; // R3
  assign mem_wr    = state_r == BMS_MOVE
                     && phase[2:0] == BMS_WRITE_STATE; // R3
  assign mem_addr  = mem_wr ? destination_pointer : source_pointer;
  assign mem_wdata = data_r;
  assign busy      = state_r != BMS_IDLE;
  assign done      = state_r == BMS_DONE;
  // Fixed instruction length regardless of form
  assign pc_advance = done ? BMS_INSTR_BYTES : 3'h0; // R7

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  int unsigned st_cnt;
  logic [15:0] n_at_start;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_cnt     <= 0;
      n_at_start <= 16'h0000;
    end else if (ce) begin
      if (state_r == BMS_IDLE && start) begin
        st_cnt     <= 0;
        n_at_start <= word_form ? word_count_register_in
                                : {8'h00, word_count_register_in[7:0]};
      end else if (busy && !done) begin
        st_cnt <= st_cnt + 1;
      end
    end
  end

  logic any_wait;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      any_wait <= 1'b0;
    end else if (ce) begin
      if (state_r == BMS_IDLE) begin
        any_wait <= 1'b0;
      end else if (mem_wait) begin
        any_wait <= 1'b1;
      end
    end
  end

  sequence start_s;
    state_r == BMS_IDLE && start && ce;
  endsequence

  byte_dec_a: assert property (@(posedge mclk) disable iff (!resetn)
    ce && !word_r && mem_wr && !mem_wait |=> word_count_register[7:0]
      == $past(word_count_register[7:0]) - 8'h01) // R1
    else $error("byte count not decremented");
  word_dec_a: assert property (@(posedge mclk) disable iff (!resetn)
    ce && word_r && mem_wr && !mem_wait |=>
      word_count_register == $past(word_count_register) - 16'h0001) // R2
    else $error("word count not decremented");
  end_zero_a: assert property (@(posedge mclk) disable iff (!resetn)
    done |-> cnt_zero) // R1
    else $error("finished with nonzero count");
  ptr_inc_a: assert property (@(posedge mclk) disable iff (!resetn)
    ce && mem_wr && !mem_wait |=>
      source_pointer == $past(source_pointer) + 16'h0001
      && destination_pointer == $past(destination_pointer) + 16'h0001) // R3
    else $error("pointers not advanced");
  rd_wr_a: assert property (@(posedge mclk) disable iff (!resetn)
    ce && mem_rd && !mem_wait |=> !mem_wait [*1] |=> mem_wr) // R3
    else $error("write did not follow read");
  zero_skip_a: assert property (@(posedge mclk) disable iff (!resetn)
    start_s ##1 (cnt_zero && !mem_wait) [*8] |=> done) // R4
    else $error("zero count did not skip");
  timing_a: assert property (@(posedge mclk) disable iff (!resetn)
    done && !any_wait && ce |-> st_cnt == 8 + 4 * n_at_start) // R5
    else $error("execution time not 8 plus 4n");
  wait_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
    ce && busy && mem_wait |=> phase == $past(phase)) // R6
    else $error("phase moved during wait");
  final_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
    done && ce |=> source_pointer == $past(source_pointer)
      && pc_advance == 3'h0) // R7
    else $error("registers not held after end");

endmodule

// File: testbench/bms_mem_model.sv
// Partner: byte memory on the sequencer's bus, with an optional slow mode.
// Assumes the bench clock; slow mode stalls each access for one state.
`timescale 1ns/10ps
module bms_mem_model (
  input  wire logic        mclk,
  input  wire logic        slow,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output logic             mem_wait,
  output logic      [7:0]  mem_rdata
);
  logic [7:0] mem [1024];
  logic       waited_r;
  logic [7:0] last_r;

  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = i[7:0] ^ 8'h5a;
    end
    waited_r = 1'b0;
    last_r = 8'h00;
  end

  // One stall per access stands in for slow-clock synchronisation
  assign mem_wait = slow & (mem_rd | mem_wr) & ~waited_r;
  // Idle bus shows the inverse, so a stale byte never matches
  assign mem_rdata = mem_rd ? mem[mem_addr[9:0]] : ~last_r;

  always @(posedge mclk) begin
    waited_r <= mem_wait;
    if (mem_rd) last_r <= mem[mem_addr[9:0]];
    if (mem_wr && !mem_wait) mem[mem_addr[9:0]] <= mem_wdata;
  end
endmodule

// File: testbench/test_cpu_block_move_sequencer.sv
// Bench: drives block moves and checks timing, data and final registers.
// Assumes the byte memory partner and a one-cycle done pulse.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module test_cpu_block_move_sequencer;
  logic        mclk = 1'b0;
  logic        ce = 1'b1;
  logic        resetn = 1'b0;
  logic        start = 1'b0;
  logic        word_form = 1'b0;
  logic        slow = 1'b0;
  logic [15:0] wcnt_in = 16'h0000;
  logic [15:0] src_in = 16'h0000;
  logic [15:0] dst_in = 16'h0000;
  logic        mem_wait, mem_rd, mem_wr, busy, done;
  logic [7:0]  mem_rdata, mem_wdata;
  logic [15:0] mem_addr, word_count_register;
  logic [15:0] source_pointer, destination_pointer;
  logic [2:0]  pc_advance;
  int          n_fail = 0;
  int          n_tests = 0;

  always #12.5 mclk = ~mclk;

  bms_seq uut (.mclk(mclk), .resetn(resetn), .ce(ce), .start(start),
    .word_form(word_form), .word_count_register_in(wcnt_in),
    .source_pointer_in(src_in), .destination_pointer_in(dst_in),
    .mem_wait(mem_wait), .mem_rdata(mem_rdata), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .word_count_register(word_count_register),
    .source_pointer(source_pointer),
    .destination_pointer(destination_pointer), .busy(busy), .done(done),
    .pc_advance(pc_advance));

  bms_mem_model mem_m (.mclk(mclk), .slow(slow), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_wait(mem_wait), .mem_rdata(mem_rdata));

  task automatic test_done();
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Shared move: a second start mid-run must be ignored
  task automatic run(input logic wf, input logic [15:0] cnt, src, dst,
                     input logic sl, input int exp_cyc,
                     input int ce_off);
    int          k;
    int          nw;
    int          n;
    logic [15:0] a;
    logic [15:0] exp_cnt;
    n = wf ? int'(cnt) : int'(cnt[7:0]);
    exp_cnt = (n == 0) ? cnt : (wf ? 16'h0000 : {cnt[15:8], 8'h00});
    @(posedge mclk);
    word_form <= wf;
    wcnt_in <= cnt;
    src_in <= src;
    dst_in <= dst;
    slow <= sl;
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    k = 0;
    nw = 0;
    while (done !== 1'b1 && k < 2000) begin
      @(posedge mclk);
      k++;
      if (k == 3) start <= 1'b1;
      if (k == 3) wcnt_in <= ~cnt;
      if (k == 4) start <= 1'b0;
      // Enable dropped during setup; every frozen state adds one
      if (k == 2 && ce_off > 0) ce <= 1'b0;
      if (k == 2 + ce_off && ce_off > 0) ce <= 1'b1;
      #1;
      if (mem_wr === 1'b1 && mem_wait === 1'b0) nw++;
    end
    if (sl == 1'b0) `CHK("cycles", exp_cyc, k)
    if (sl == 1'b1) `CHK("slow cycles", exp_cyc, k)
    `CHK("writes", n, nw)
    `CHK("pc_advance", 3'h4, pc_advance)
    @(posedge mclk);
    #1;
    `CHK("done pulse", 1'b0, done)
    `CHK("busy", 1'b0, busy)
    `CHK("count", exp_cnt, word_count_register)
    `CHK("src", src + 16'(n), source_pointer)
    `CHK("dst", dst + 16'(n), destination_pointer)
    for (int i = 0; i < n; i++) begin
      a = src + 16'(i);
      `CHK("data", a[7:0] ^ 8'h5a, mem_m.mem[dst[9:0] + 10'(i)])
    end
  endtask

  task automatic t_reset();
    `CHK("reset busy", 1'b0, busy)
    `CHK("reset count", 16'h0000, word_count_register)
  endtask

  // Upper byte must survive the byte form
  task automatic t_byte_form();
    run(1'b0, 16'h1203, 16'h0010, 16'h0300, 1'b0, 8 + 4 * 3, 0);
  endtask

  // Three frozen states in setup stretch the run by three
  task automatic t_ce_freeze();
    run(1'b0, 16'h0002, 16'h0030, 16'h03c0, 1'b0, 8 + 4 * 2 + 3, 3);
  endtask

  // Zero count: byte form with low byte zero moves nothing, word form with count 0 moves nothing
  task automatic t_zero_count();
    run(1'b0, 16'h0100, 16'h0040, 16'h0340, 1'b0, 8, 0);
    run(1'b1, 16'h0000, 16'h0040, 16'h0340, 1'b0, 8, 0);
  endtask

  task automatic t_word_form();
    run(1'b1, 16'h0100, 16'h0000, 16'h0100, 1'b0, 8 + 4 * 256, 0);
  endtask

  // One stall per access adds one state per access
  task automatic t_slow();
    run(1'b0, 16'h0002, 16'h0020, 16'h0380, 1'b1, 8 + 6 * 2, 0);
  endtask

  initial begin
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    #1;
    t_reset();
    t_byte_form();
    t_zero_count();
    t_word_form();
    t_slow();
    t_ce_freeze();
    test_done();
  end

  initial begin
    repeat (4000) @(posedge mclk);
    n_fail++;
    test_done();
  end
endmodule
